// File: adcseq_map.svh
// Register map, field positions, reset values and timing counts of the trigger sequencer
// Notes on behaviour
// - No-wait: enabling from stop enters conversion standby
// - No-wait: start bit enters trigger standby only
// - In trigger standby, start alone never converts
// - Select: trigger with start converts selected channel
// - Each conversion end not overridden by a restart or abort in the same cycle stores result, raises interrupt
// - Select single: start stays one, back to standby
// - Trigger mid-conversion aborts, restarts from first channel
// - Channel-select write mid-conversion restarts with new setting
// - Start write mid-conversion restarts from first channel
// - No-wait: start clear aborts, standby, not stopped
// - Enable clear stops; start ignored while disabled
// - No-wait: triggers ignored while start bit is zero
// - Scan: four slots converted in order from zero
// - Scan continuous: new pass after four channels
// - Scan single: start stays one, back to standby
// - Wait mode: enable goes straight to trigger standby
// - Wait mode: trigger converts and sets start bit
// - Wait continuous: each end launches next conversion
// - Wait mode: start clear aborts, standby, converter off
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

`define ADCSEQ_OFS_CTRL 8'h00
`define ADCSEQ_OFS_CHSEL 8'h04
`define ADCSEQ_OFS_RES 8'h08
`define ADCSEQ_OFS_RESH 8'h0C
`define ADCSEQ_OFS_STAT 8'h10

`define ADCSEQ_BIT_EN 0
`define ADCSEQ_BIT_START 1
`define ADCSEQ_BIT_SCAN 2
`define ADCSEQ_BIT_CONT 3
`define ADCSEQ_BIT_WAIT 4

`define ADCSEQ_RST_CTRL 5'h00
`define ADCSEQ_RST_CHSEL 5'h00

`define ADCSEQ_STAB_NS 1000
`define ADCSEQ_CLK_MHZ 10
`define ADCSEQ_SCAN_SLOTS 4

`endif

// File: adcseq_pkg.sv
// Types shared by the trigger sequencer
package adcseq_pkg;

   typedef enum logic [1:0] {
      ADCSEQ_STOP = 2'b00,
      ADCSEQ_ADSTBY = 2'b01,
      ADCSEQ_HWSTBY = 2'b10,
      ADCSEQ_CONV = 2'b11
   } adcseq_state_t;

   typedef struct packed {
      logic wait_mode;
      logic cont;
      logic scan;
      logic start;
      logic enable;
   } adcseq_ctrl_t;

   typedef struct packed {
      logic start;
      logic abort;
      logic [4:0] chan;
   } adcseq_core_req_t;

endpackage : adcseq_pkg

// File: adcseq_top.sv
// Hardware-trigger conversion sequencer with a classic Wishbone register slave
`timescale 1ns/100ps
`include "adcseq_map.svh"

module adcseq_top
   import adcseq_pkg::*;
#(
   parameter int RES_W = 12,
   parameter int CH_W = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic hw_trigger_i,
   input wire logic core_done_i,
   input wire logic [RES_W-1:0] core_data_i,
   output adcseq_core_req_t core_req_o,
   output logic core_power_o,
   output logic conversion_end_irq_o
);

   localparam int STAB_CYC = (`ADCSEQ_STAB_NS * `ADCSEQ_CLK_MHZ + 999) / 1000;
   localparam logic [1:0] LAST_SLOT = 2'(`ADCSEQ_SCAN_SLOTS - 1);

   // Channel of a scan slot; select mode always uses the base channel
   function automatic logic [4:0] chan_of(
      input logic [4:0] base,
      input logic [1:0] slot,
      input logic scan
   );
      logic [4:0] c;
      c = base;
      if (scan) begin
         c = 5'(base + {3'h0, slot});
      end
      return c;
   endfunction : chan_of

   // Register hit decode, shared by the read mux and the write strobes
   function automatic logic hit(
      input logic [7:0] adr,
      input logic [7:0] ofs
   );
      return adr[7:2] == ofs[7:2];
   endfunction : hit

   // Bus signals
   logic ack_q;
   logic [31:0] rdat_q;
   logic wr_ok;
   logic wr_ctrl;
   logic wr_chsel;
   logic wr_start1;
   logic wr_start0;

   // Configuration
   logic enable_q;
   logic scan_q;
   logic cont_q;
   logic wait_q;
   logic [CH_W-1:0] chsel_q;
   logic [4:0] chsel_n;

   // Sequencer state
   adcseq_state_t state_q;
   logic start_q;
   logic [1:0] slot_q;
   adcseq_core_req_t req_q;
   logic irq_q;
   logic power_q;
   logic [RES_W-1:0] result_q;
   logic [7:0] stab_cnt_q;
   logic stab_ok;

   // Trigger synchroniser and edge detect
   logic trig_s1_q;
   logic trig_s2_q;
   logic trig_s3_q;
   logic trig_evt;

   // A write lands at the edge where the master sees ack high
   assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
   assign wr_ctrl = wr_ok & hit(wb_adr_i, `ADCSEQ_OFS_CTRL);
   assign wr_chsel = wr_ok & hit(wb_adr_i, `ADCSEQ_OFS_CHSEL);
   assign wr_start1 = wr_ctrl & wb_dat_i[`ADCSEQ_BIT_START];
   assign wr_start0 = wr_ctrl & ~wb_dat_i[`ADCSEQ_BIT_START];

   // Restart uses the value being written this very edge
   assign chsel_n = wr_chsel ? 5'(wb_dat_i[CH_W-1:0]) : 5'(chsel_q);

   // Only the pulse's rising edge counts, so a held trigger restarts once
   assign trig_evt = trig_s2_q & ~trig_s3_q;

   assign stab_ok = stab_cnt_q >= 8'(STAB_CYC);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end else begin
         trig_s1_q <= hw_trigger_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   // Wishbone handshake: ack one cycle after the request, dropped after one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end

   // Read data is captured with the ack; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else begin
         rdat_q <= 32'h0000_0000;
         if (wb_cyc_i & wb_stb_i & ~ack_q) begin
            if (hit(wb_adr_i, `ADCSEQ_OFS_CTRL)) begin
               rdat_q[`ADCSEQ_BIT_EN] <= enable_q;
               rdat_q[`ADCSEQ_BIT_START] <= start_q;
               rdat_q[`ADCSEQ_BIT_SCAN] <= scan_q;
               rdat_q[`ADCSEQ_BIT_CONT] <= cont_q;
               rdat_q[`ADCSEQ_BIT_WAIT] <= wait_q;
            end else if (hit(wb_adr_i, `ADCSEQ_OFS_CHSEL)) begin
               rdat_q[CH_W-1:0] <= chsel_q;
            end else if (hit(wb_adr_i, `ADCSEQ_OFS_RES)) begin
               rdat_q[RES_W-1:0] <= result_q;
            end else if (hit(wb_adr_i, `ADCSEQ_OFS_RESH)) begin
               rdat_q[7:0] <= result_q[RES_W-1 -: 8];
            end else if (hit(wb_adr_i, `ADCSEQ_OFS_STAT)) begin
               rdat_q[1:0] <= state_q;
               rdat_q[3:2] <= slot_q;
               rdat_q[4] <= stab_ok;
               rdat_q[5] <= power_q;
            end
         end
      end
   end

   // Mode and enable bits; the start bit lives with the sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {wait_q, cont_q, scan_q} <= 3'h0;
         enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         enable_q <= wb_dat_i[`ADCSEQ_BIT_EN];
         scan_q <= wb_dat_i[`ADCSEQ_BIT_SCAN];
         cont_q <= wb_dat_i[`ADCSEQ_BIT_CONT];
         wait_q <= wb_dat_i[`ADCSEQ_BIT_WAIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chsel_q <= CH_W'(`ADCSEQ_RST_CHSEL);
      end else if (wr_chsel) begin
         chsel_q <= wb_dat_i[CH_W-1:0];
      end
   end

   // Settle time after enable; software reads it rather than counting itself
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stab_cnt_q <= 8'h00;
      end else if (!enable_q) begin
         stab_cnt_q <= 8'h00;
      end else if (!stab_ok) begin
         stab_cnt_q <= 8'(stab_cnt_q + 8'h01);
      end
   end

   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ADCSEQ_STOP;
         start_q <= 1'b0;
         slot_q <= 2'h0;
         req_q <= '0;
         irq_q <= 1'b0;
         result_q <= '0;
      end else begin
         req_q.start <= 1'b0;
         req_q.abort <= 1'b0;
         irq_q <= 1'b0;
         if (!enable_q) begin
            // Disabled: start writes have no effect
            req_q.abort <= state_q == ADCSEQ_CONV;
            state_q <= ADCSEQ_STOP;
            start_q <= 1'b0;
         end else begin
            unique case (state_q)
               ADCSEQ_STOP: begin
                  if (wait_q) begin
                     state_q <= ADCSEQ_HWSTBY;
                  end else begin
                     state_q <= ADCSEQ_ADSTBY;
                  end
               end
               ADCSEQ_ADSTBY: begin
                  // No conversion starts here, only trigger standby
                  if (wr_start1) begin
                     start_q <= 1'b1;
                     state_q <= ADCSEQ_HWSTBY;
                  end
               end
               ADCSEQ_HWSTBY: begin
                  if (!wait_q && wr_start0) begin
                     start_q <= 1'b0;
                     state_q <= ADCSEQ_ADSTBY;
                  end else if (trig_evt && (start_q || wait_q)) begin
                     // A start write alone is not enough; the trigger is
                     start_q <= 1'b1;
                     slot_q <= 2'h0;
                     req_q.start <= 1'b1;
                     req_q.chan <= chan_of(chsel_n, 2'h0, scan_q);
                     state_q <= ADCSEQ_CONV;
                  end
               end
               ADCSEQ_CONV: begin
                  if (wr_start0) begin
                     req_q.abort <= 1'b1;
                     start_q <= 1'b0;
                     state_q <= wait_q ? ADCSEQ_HWSTBY : ADCSEQ_ADSTBY;
                  end else if (wr_start1 || wr_chsel || trig_evt) begin
                     // Restart wins over a conversion end in the same cycle
                     slot_q <= 2'h0;
                     req_q.start <= 1'b1;
                     req_q.chan <= chan_of(chsel_n, 2'h0, scan_q);
                  end else if (core_done_i) begin
                     result_q <= core_data_i;
                     irq_q <= 1'b1;
                     if (scan_q && slot_q != LAST_SLOT) begin
                        slot_q <= 2'(slot_q + 2'h1);
                        req_q.start <= 1'b1;
                        req_q.chan <= chan_of(chsel_n, 2'(slot_q + 2'h1), 1'b1);
                     end else if (cont_q || wait_q) begin
                        slot_q <= 2'h0;
                        req_q.start <= 1'b1;
                        req_q.chan <= chan_of(chsel_n, 2'h0, scan_q);
                     end else begin
                        // Single pass done; start stays set for the next trigger
                        slot_q <= 2'h0;
                        state_q <= ADCSEQ_HWSTBY;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Wait mode keeps the converter unpowered until a trigger arrives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_q <= 1'b0;
      end else begin
         power_q <= enable_q & ((state_q == ADCSEQ_CONV)
            | (~wait_q & (state_q != ADCSEQ_STOP)));
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign core_req_o = req_q;
   assign core_power_o = power_q;
   assign conversion_end_irq_o = irq_q;

endmodule : adcseq_top

// File: adcseq_core_model.sv
// Behavioural analog core that answers start and abort requests
`timescale 1ns/100ps
module adcseq_core_model
   import adcseq_pkg::*;
#(
   parameter int CONV = 30
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire adcseq_core_req_t req_i,
   output logic done_o,
   output logic [11:0] data_o
);
   int cnt_q;
   logic [4:0] ch_q;
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i || req_i.abort) begin
         cnt_q <= 0;
      end else if (req_i.start) begin
         cnt_q <= CONV;
         ch_q <= req_i.chan;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
         done_o <= (cnt_q == 1);
      end
   end
   // Outside done the data toggles, so a stale capture cannot pass
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_o <= 12'h555;
      end else begin
         data_o <= (cnt_q == 1) ? {7'h50, ch_q} : ~data_o;
      end
   end
endmodule : adcseq_core_model

// File: adcseq_chk.sv
// Port-level assertions for the trigger sequencer
`timescale 1ns/100ps
module adcseq_chk
   import adcseq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic core_done_i,
   input wire adcseq_core_req_t core_req_o,
   input wire logic conversion_end_irq_o,
   input wire logic hw_trigger_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("data without ack");
   AST_IRQ_CAUSE: assert property (conversion_end_irq_o |-> $past(core_done_i))
      else $error("irq without done");
   AST_IRQ_PULSE: assert property (conversion_end_irq_o |=> !conversion_end_irq_o)
      else $error("irq held");
   // Back-to-back starts need a fresh cause; a held pin is not one
   AST_START_PULSE: assert property (core_req_o.start |=> !core_req_o.start
      || $past(wb_ack_o) || $past(core_done_i)
      || ($past(hw_trigger_i, 3) && !$past(hw_trigger_i, 4)))
      else $error("start held");
   AST_START_ABORT: assert property (!(core_req_o.start && core_req_o.abort))
      else $error("start with abort");
   AST_CHAN_HOLD: assert property (!core_req_o.start |-> $stable(core_req_o.chan))
      else $error("chan moved");
endmodule : adcseq_chk
bind adcseq_top adcseq_chk u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o),
   .core_done_i(core_done_i),
   .core_req_o(core_req_o),
   .conversion_end_irq_o(conversion_end_irq_o),
   .hw_trigger_i(hw_trigger_i)
);

// File: adcseq_top_tb.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/100ps
module adcseq_top_tb
   import adcseq_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rq = 1'b0;
   logic we = 1'b0;
   logic trig = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdo, q;
   logic ack, done, irq, pwr;
   logic [11:0] cdat;
   adcseq_core_req_t req;
   int mismatches = 0, checked = 0, ns = 0, ni = 0, na = 0, cyc_cnt = 0;
   logic [4:0] ch[$];
   logic [4:0] e;
   always #50 clk_i = ~clk_i;
   adcseq_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(rq), .wb_stb_i(rq),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo),
      .wb_ack_o(ack), .hw_trigger_i(trig), .core_done_i(done), .core_data_i(cdat),
      .core_req_o(req), .core_power_o(pwr), .conversion_end_irq_o(irq));
   adcseq_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .done_o(done),
      .data_o(cdat));
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (req.start === 1'b1) begin
         ns++;
         ch.push_back(req.chan);
      end
      if (irq === 1'b1) begin
         ni++;
      end
      if (req.abort === 1'b1) begin
         na++;
      end
      if (cyc_cnt == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      rq <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdo;
      rq <= 1'b0;
   endtask : wb
   // Leaves room for the restart pulse to be seen by the monitor
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'h1, a, d);
      repeat (3) @(posedge clk_i);
   endtask : wr
   task automatic stc(input logic [1:0] x);
      wb(1'h0, 8'h10, 32'h0);
      chk("state", q[1:0], x);
   endtask : stc
   task automatic trg();
      @(posedge clk_i);
      trig <= 1'b1;
      repeat (8) @(posedge clk_i);
      trig <= 1'b0;
   endtask : trg
   task automatic wirq(input int n);
      repeat (300) if (ni < n) @(posedge clk_i);
      chk("irqs", ni, n);
   endtask : wirq
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'h0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h0);
      wb(1'h0, 8'h20, 32'h0);
      chk("unmapped", q, 32'h0);
      wr(8'h04, 32'h5);
      wr(8'h00, 32'h1);
      stc(2'h1);
      repeat (10) @(posedge clk_i);
      wr(8'h00, 32'h3);
      stc(2'h2);
      chk("settled", q[4], 1'h1);
      repeat (20) @(posedge clk_i);
      chk("idle", ns, 0);
      trg();
      wirq(1);
      chk("chan", ch[0], 32'h5);
      wb(1'h0, 8'h08, 32'h0);
      chk("result", q, {7'h50, 5'h05});
      wb(1'h0, 8'h0C, 32'h0);
      chk("result hi", q, 32'hA0);
      wb(1'h0, 8'h00, 32'h0);
      chk("start kept", q[1], 1'h1);
      stc(2'h2);
      trg();
      trg();
      chk("retrigger", ns, 3);
      wr(8'h04, 32'h9);
      chk("new chan", ch[3], 32'h9);
      wr(8'h00, 32'h3);
      chk("start restart", ns, 5);
      wr(8'h00, 32'h1);
      stc(2'h1);
      chk("power kept", pwr, 1'h1);
      chk("aborted", ni, 1);
      chk("abort", na, 1);
      trg();
      chk("ignored", ns, 5);
      wr(8'h04, 32'h1E);
      wr(8'h00, 32'h7);
      ch.delete();
      trg();
      wirq(5);
      for (int i = 0; i < 4; i++) begin
         e = 5'h1E + 5'(i);
         chk("scan chan", ch[i], e);
      end
      repeat (40) @(posedge clk_i);
      chk("one pass", ch.size(), 4);
      stc(2'h2);
      wr(8'h00, 32'hF);
      ch.delete();
      trg();
      wirq(10);
      chk("rescan", ch[4], 32'h1E);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h0);
      stc(2'h0);
      wr(8'h00, 32'h2);
      stc(2'h0);
      chk("power off", pwr, 1'h0);
      chk("abort", na, 2);
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h11);
      stc(2'h2);
      trg();
      wb(1'h0, 8'h00, 32'h0);
      chk("auto start", q[1], 1'h1);
      chk("power on", pwr, 1'h1);
      ch.delete();
      wirq(12);
      chk("auto next", ch.size(), 2);
      wr(8'h00, 32'h11);
      stc(2'h2);
      chk("power", q[5], 1'h0);
      chk("power pin", pwr, 1'h0);
      chk("abort", na, 3);
      print_verdict();
   end
endmodule : adcseq_top_tb
